// ===== logic/rail_seq_pkg.sv
`default_nettype none
package rail_seq_pkg;
    // register map
    localparam logic [7:0] CTRL_OFFSET    = 8'h02;
    localparam logic [7:0] STATUS_OFFSET  = 8'h03;
    localparam logic [7:0] MATRIX_OFFSET  = 8'h04;
    localparam logic [7:0] STRETCH_OFFSET = 8'h05;
    // reset values
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] MATRIX_RESET   = 8'h00;
    localparam logic [7:0] STRETCH_RESET  = 8'h00;
    // control fields
    localparam int         ENABLE_BIT     = 0;
    localparam int         LAUNCH_BIT     = 6;
    // matrix and stretch fields
    localparam int         SW_ROW_LSB     = 0;
    localparam int         POS_ROW_LSB    = 3;
    localparam int         NEG_ROW_LSB    = 0;
    localparam int         STRETCH1_LSB   = 3;
    localparam int         STRETCH2_LSB   = 5;
    // status fields
    localparam int         ON_BIT         = 3;
    localparam int         BUSY_BIT       = 4;
    // timing
    localparam int         CNT_W          = 16;
    localparam logic [CNT_W+1:0] PCT_STEP_DIV = 18'h0_000A; // each code step is one tenth
    localparam logic [1:0] NO_SLOT        = 2'h3;
    localparam logic [1:0] LAST_SLOT      = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_UP_RAMP, ST_UP_WAIT, ST_DN_WAIT} seq_state_type;
endpackage
`default_nettype wire

// ===== logic/three_slot_rail_sequencer.sv
// Behaviour
// R1 - rail switch slot comes from matrix register bits 2:0
// R2 - positive pump slot comes from matrix register bits 5:3
// R3 - negative pump slot comes from stretch register bits 2:0
// R4 - with several set bits in a row only the first counts
// R5 - slot 2 starts after slot 1 ramp time times one plus stretch
// R6 - slot 3 starts likewise using second stretch field and slot 2 ramp
// R7 - stretch codes add 0, 10, 20 or 30 percent of ramp time
// R8 - launch bit high powers up when off, low powers down when on
// R9 - slot and stretch programming is frozen while a sequence runs
// R10 - launch bit does nothing while the sequencer enable is low
// R11 - bit zero is slot 1, lowest set bit wins, empty row never starts
// R12 - empty slots skipped at once on power-up, power-down runs slots in reverse
`timescale 1ns/1ps
`default_nettype none
module three_slot_rail_sequencer
    import rail_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    output logic      [7:0]  reg_rdata,
    input  wire logic [2:0]  rail_good,
    output logic      [2:0]  rail_en,
    output logic             seq_busy,
    output logic             rails_on
);
    // slot index of a row: lowest set bit, bit zero is slot 1
    function automatic logic [1:0] slot_of(input logic [2:0] row);
        if (row[0]) begin
            slot_of = 2'h0; // [R11]
        end else if (row[1]) begin
            slot_of = 2'h1; // [R4]
        end else if (row[2]) begin
            slot_of = 2'h2;
        end else begin
            slot_of = NO_SLOT; // [R11]
        end
    endfunction

    // ramp time scaled by code tenths, as added stretch
    function automatic logic [CNT_W-1:0] stretch_of(input logic [CNT_W-1:0] ramp,
                                                    input logic [1:0] code);
        logic [CNT_W+1:0] prod;
        prod = {2'b00, ramp} * {{CNT_W{1'b0}}, code};
        stretch_of = CNT_W'(prod / PCT_STEP_DIV); // [R7]
    endfunction

    logic [7:0]            ctrl_q;
    logic [7:0]            matrix_q;
    logic [7:0]            stretch_q;
    logic [2:0]            good_meta_q;
    logic [2:0]            good_sync_q;
    seq_state_type         state_q;
    logic [1:0]            slot_q;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      gap_q [0:1];
    logic [2:0]            rail_en_q;
    logic                  on_q;
    logic                  busy_q;
    logic [7:0]            rdata_q;

    // field decode
    wire [2:0] rail_switch_slot_row     = matrix_q[SW_ROW_LSB +: 3];   // [R1]
    wire [2:0] pos_pump_slot_row        = matrix_q[POS_ROW_LSB +: 3];  // [R2]
    wire [2:0] neg_pump_slot_row        = stretch_q[NEG_ROW_LSB +: 3]; // [R3]
    wire [1:0] stretch_after_first_slot  = stretch_q[STRETCH1_LSB +: 2];
    wire [1:0] stretch_after_second_slot = stretch_q[STRETCH2_LSB +: 2];
    wire       seq_enable = ctrl_q[ENABLE_BIT];
    wire       launch     = ctrl_q[LAUNCH_BIT];
    wire       idle       = (state_q == ST_IDLE);

    // rails that belong to the slot in hand
    wire [2:0] members = {slot_of(neg_pump_slot_row) == slot_q,
                          slot_of(pos_pump_slot_row) == slot_q,
                          slot_of(rail_switch_slot_row) == slot_q};
    wire       members_good = ((good_sync_q & members) == members);
    wire [1:0] cur_code     = (slot_q == 2'h0) ? stretch_after_first_slot
                                               : stretch_after_second_slot; // [R6]
    wire [CNT_W-1:0] ramp_next = (cnt_q == {CNT_W{1'b1}}) ? cnt_q : cnt_q + 1'b1;
    wire [CNT_W-1:0] ext       = stretch_of(cnt_q, cur_code);
    wire [CNT_W-1:0] dn_gap    = (slot_q == 2'h2) ? gap_q[1] :
                                 (slot_q == 2'h1) ? gap_q[0] : {CNT_W{1'b0}};
    wire       start_up   = idle && seq_enable && launch && !on_q;   // [R8] [R10]
    wire       start_dn   = idle && seq_enable && !launch && on_q;   // [R8] [R10]
    wire       prog_write = reg_we && idle;                          // [R9]

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q    <= CTRL_RESET;
            matrix_q  <= MATRIX_RESET;
            stretch_q <= STRETCH_RESET;
        end else begin
            if (reg_we && reg_addr == CTRL_OFFSET) begin
                ctrl_q <= reg_wdata & 8'h41;
            end
            if (prog_write && reg_addr == MATRIX_OFFSET) begin
                matrix_q <= reg_wdata & 8'h3F; // [R9]
            end
            if (prog_write && reg_addr == STRETCH_OFFSET) begin
                stretch_q <= reg_wdata & 8'h7F; // [R9]
            end
        end
    end

    // power-good synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            good_meta_q <= 3'h0;
            good_sync_q <= 3'h0;
        end else begin
            good_meta_q <= rail_good;
            good_sync_q <= good_meta_q;
        end
    end

    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            slot_q    <= 2'h0;
            cnt_q     <= {CNT_W{1'b0}};
            gap_q[0]  <= {CNT_W{1'b0}};
            gap_q[1]  <= {CNT_W{1'b0}};
            rail_en_q <= 3'h0;
            on_q      <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    slot_q <= start_up ? 2'h0 : LAST_SLOT;
                    cnt_q  <= {CNT_W{1'b0}};
                    if (start_up) begin
                        state_q <= ST_UP_RAMP;
                        busy_q  <= 1'b1;
                    end else if (start_dn) begin
                        state_q <= ST_DN_WAIT;
                        busy_q  <= 1'b1;
                        cnt_q   <= {CNT_W{1'b1}}; // marks first pass of a slot
                    end
                end
                ST_UP_RAMP: begin
                    rail_en_q <= rail_en_q | members; // power-on issued for this slot
                    if (members == 3'h0) begin
                        if (slot_q != LAST_SLOT) begin
                            gap_q[slot_q[0]] <= {CNT_W{1'b0}}; // [R12]
                        end
                        cnt_q <= {CNT_W{1'b0}};
                        if (slot_q == LAST_SLOT) begin
                            state_q <= ST_IDLE;
                            busy_q  <= 1'b0;
                            on_q    <= 1'b1;
                        end else begin
                            slot_q <= slot_q + 2'h1; // [R12]
                        end
                    end else if (members_good && ((rail_en_q & members) == members)) begin
                        if (slot_q == LAST_SLOT) begin
                            state_q <= ST_IDLE;
                            busy_q  <= 1'b0;
                            on_q    <= 1'b1;
                        end else begin
                            gap_q[slot_q[0]] <= cnt_q + ext; // [R5] [R6]
                            cnt_q   <= ext;
                            state_q <= ST_UP_WAIT;
                        end
                    end else begin
                        cnt_q <= ramp_next; // measure ramp time
                    end
                end
                ST_UP_WAIT: begin
                    if (cnt_q == {CNT_W{1'b0}}) begin
                        slot_q  <= slot_q + 2'h1; // [R5]
                        state_q <= ST_UP_RAMP;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_DN_WAIT: begin
                    if (cnt_q == {CNT_W{1'b1}}) begin
                        rail_en_q <= rail_en_q & ~members; // [R12]
                        cnt_q     <= dn_gap;
                    end else if (cnt_q == {CNT_W{1'b0}}) begin
                        if (slot_q == 2'h0) begin
                            state_q   <= ST_IDLE;
                            busy_q    <= 1'b0;
                            on_q      <= 1'b0;
                            rail_en_q <= 3'h0; // rows edited while on still end all off
                        end else begin
                            slot_q <= slot_q - 2'h1; // [R12]
                            cnt_q  <= {CNT_W{1'b1}};
                        end
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // registered read data
    wire [7:0] status_word = {3'h0, busy_q, on_q, rail_en_q};
    wire [7:0] read_mux = (reg_addr == CTRL_OFFSET)    ? ctrl_q :
                          (reg_addr == STATUS_OFFSET)  ? status_word :
                          (reg_addr == MATRIX_OFFSET)  ? matrix_q :
                          (reg_addr == STRETCH_OFFSET) ? stretch_q : 8'h00;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= read_mux;
        end
    end

    assign reg_rdata = rdata_q;
    assign rail_en   = rail_en_q;
    assign seq_busy  = busy_q;
    assign rails_on  = on_q;
endmodule // three_slot_rail_sequencer
`default_nettype wire

// ===== verification/rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// regulators: power-good follows an enable held for RAMP cycles, drops at once
module rail_model #(
    parameter int RAMP = 40
) (
    input  wire logic       clk,
    input  wire logic [2:0] rail_en,
    output var  logic [2:0] rail_good
);
    int cnt [3] = '{0, 0, 0};
    // per rail ramp counter
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] <= rail_en[i] ? cnt[i] + 1 : 0;
            rail_good[i] <= rail_en[i] && cnt[i] >= RAMP - 1;
        end
    end
endmodule // rail_model
`default_nettype wire

// ===== verification/three_slot_rail_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rail_seq_monitor
    import rail_seq_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] rail_good,
    input wire logic [2:0] rail_en,
    input wire logic       seq_busy,
    input wire logic       rails_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // control write while idle with rails off
    wire ctl_wr = reg_we && reg_addr == CTRL_OFFSET && !seq_busy && !rails_on;
    AST_IDLE_OFF: assert property (!seq_busy && !rails_on |-> rail_en == 3'h0)
        else $error("rail enabled while idle");
    AST_NO_LAUNCH: assert property (ctl_wr && !reg_wdata[0] |=> !seq_busy [*2])
        else $error("sequence ran while disabled");
    AST_LAUNCH: assert property (
        ctl_wr && reg_wdata[0] && reg_wdata[6] |-> ##[1:2] seq_busy)
        else $error("power-up not launched");
    AST_ON_STABLE: assert property (rails_on && !seq_busy && !reg_we |=> $stable(rail_en))
        else $error("rails changed while on");
    AST_UP_RISE: assert property (
        seq_busy && !rails_on |=> (rail_en & $past(rail_en)) == $past(rail_en))
        else $error("rail dropped in power-up");
    AST_GOOD_FIRST: assert property (
        seq_busy && !rails_on && $past(rail_en) != 3'h0
        && (rail_en & ~$past(rail_en)) != 3'h0
        |-> (rail_good & $past(rail_en)) == $past(rail_en))
        else $error("next slot before power-good");
    AST_STATUS: assert property (
        reg_addr == STATUS_OFFSET
        |=> reg_rdata == {3'h0, $past(seq_busy), $past(rails_on), $past(rail_en)})
        else $error("status read wrong");
    AST_MATRIX_RB: assert property (
        reg_we && reg_addr == MATRIX_OFFSET && !seq_busy ##1 reg_addr == MATRIX_OFFSET && !reg_we
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3F))
        else $error("matrix readback wrong");
endmodule // rail_seq_monitor
bind three_slot_rail_sequencer rail_seq_monitor rail_seq_monitor_i (
    .clk       (clk),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .reg_rdata (reg_rdata),
    .rail_good (rail_good),
    .rail_en   (rail_en),
    .seq_busy  (seq_busy),
    .rails_on  (rails_on)
);
`default_nettype wire

// ===== verification/three_slot_rail_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module three_slot_rail_sequencer_tb;
    import rail_seq_pkg::*;
    localparam int RMP = 40;
    logic       clk = 1'b0, rst = 1'b1, reg_we = 1'b0, seq_busy, rails_on;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] rail_good, rail_en;
    int         n_errors = 0, cmp_count = 0, cyc = 0, t0, tg, t1;
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    three_slot_rail_sequencer three_slot_rail_sequencer_i (
        .clk       (clk),
        .rst       (rst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_we    (reg_we),
        .reg_rdata (reg_rdata),
        .rail_good (rail_good),
        .rail_en   (rail_en),
        .seq_busy  (seq_busy),
        .rails_on  (rails_on)
    );
    rail_model #(.RAMP(RMP)) rail_model_i (.clk(clk), .rail_en(rail_en), .rail_good(rail_good));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
        @(posedge clk) reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) reg_addr <= a;
        @(posedge clk) #1 check(reg_rdata, exp);
    endtask
    // bounded wait: 0 enables, 1 power-good, 2 rails on
    task automatic wt(input int w, input logic [2:0] m, output int t);
        for (int i = 0; i <= 3000; i++) begin
            @(posedge clk) #1;
            if ((w == 0 ? rail_en : w == 1 ? rail_good : {2'h0, rails_on}) === m) break;
            if (i == 3000) begin
                n_errors++;
                conclude();
            end
        end
        t = cyc;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(MATRIX_OFFSET, MATRIX_RESET);
        rd(STRETCH_OFFSET, STRETCH_RESET);
        // switch row 110 starts in slot 2, pos pump slot 1, neg pump slot 3
        wr(MATRIX_OFFSET, 8'h0E);
        rd(MATRIX_OFFSET, 8'h0E);
        wr(STRETCH_OFFSET, 8'h3C);
        wr(CTRL_OFFSET, 8'h40);
        repeat (20) @(posedge clk);
        check(rail_en, 3'h0);
        check(seq_busy, 1'b0);
        wr(CTRL_OFFSET, 8'h41);
        wr(MATRIX_OFFSET, 8'h00);
        wt(0, 3'b010, t0);
        wt(1, 3'b010, tg);
        wt(0, 3'b011, t1);
        check((t1 - tg) inside {[RMP * 3 / 10 + 3 : RMP * 3 / 10 + 7]}, 1'b1);
        wt(1, 3'b011, tg);
        wt(0, 3'b111, t1);
        check((t1 - tg) inside {[RMP / 10 + 3 : RMP / 10 + 7]}, 1'b1);
        wt(2, 3'b001, t0);
        check(seq_busy, 1'b0);
        rd(STATUS_OFFSET, 8'h0F);
        rd(MATRIX_OFFSET, 8'h0E);
        // power-down walks slots 3, 2, 1
        wr(CTRL_OFFSET, 8'h01);
        wt(0, 3'b011, t0);
        wt(0, 3'b010, t1);
        check((t1 - t0) inside {[RMP + RMP / 10 : RMP + RMP / 10 + 9]}, 1'b1);
        wt(0, 3'b000, t0);
        check((t0 - t1) inside {[RMP + RMP * 3 / 10 : RMP + RMP * 3 / 10 + 9]}, 1'b1);
        wt(2, 3'b000, t0);
        check(rail_en, 3'h0);
        // pos pump alone in slot 3: empty slots and an empty row are skipped
        wr(MATRIX_OFFSET, 8'h20);
        rd(MATRIX_OFFSET, 8'h20);
        wr(STRETCH_OFFSET, 8'h00);
        wr(CTRL_OFFSET, 8'h41);
        wt(2, 3'b001, t0);
        check(rail_en, 3'h2);
        wr(CTRL_OFFSET, 8'h01);
        wt(2, 3'b000, t0);
        check(rail_en, 3'h0);
        conclude();
    end
endmodule // three_slot_rail_sequencer_tb
`default_nettype wire
